// *** usb_peripheral_front_end.sv ***
// Purpose: Host interface, DMA handler, endpoint RAM release and speed detection
// Assumes: Pins synchronous to clk_sys; serial engine events arrive as pulses
// Notes: Behaviour
// Behaviour
// (RULE1) Firmware command opcode selects generic DMA, PIO or multi-word DMA.
// (RULE2) DMA handler moves words between endpoint RAM and the DMA bus.
// (RULE3) DMA uses read/write strobes or request/acknowledge handshake, per configuration.
// (RULE4) PIO and multi-word DMA for IDE; generic DMA slave otherwise.
// (RULE5) Firmware sets DMA endpoint lengths as multiples of four bytes.
// (RULE6) Endpoint data released only after controller read or full DMA drain; code releases on any completed to-device DMA.
// (RULE7) Clear-buffer bit discards residual data of the selected endpoint.
// (RULE8) Firmware clears double-buffered OUT endpoint by repeated index and clear writes.
// (RULE9) Host interface configuration taken from the strap pins.
// (RULE10) Bus config high: separate address and data; low: multiplexed bus.
// (RULE11) Strobe style high: read/write strobes; low: direction plus data strobe.
// (RULE12) Latch style low latches address; high marks address or data phase.
// (RULE13) Board holds latch style high in separate bus mode.
// (RULE14) High-speed path is sixteen bits wide with stuffing and NRZI.
// (RULE15) Device starts full-speed and stays until a bus reset.
// (RULE16) Bus reset starts a chirp; high-speed only after host chirp answer.
// (RULE17) Three milliseconds idle in high-speed returns to full-speed and SE0 check.
// (RULE18) SE0 within 100 to 875 us restarts chirp, else suspend.
// (RULE19) Serial engine duties run in hardware without firmware.
// (RULE20) Pull-up pin drives only while pullup_connect is set; reset clears it.
// (RULE21) USB bus reset leaves pullup_connect unchanged.
// (RULE22) Firmware keeps pullup_connect clear without VBUS.
// (RULE23) DMA data bus stays undriven until the first DMA command runs.
// (RULE24) Strap levels captured once after reset release.
// (RULE25) Speed timers run from the clock and restart on activity or state change.
`timescale 1ns/10ps
module usb_peripheral_front_end
    import front_end_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic bus_config_select,
    input wire logic strobe_style_select,
    input wire logic address_latch_style,
    input wire logic chip_select_n,
    input wire logic read_or_dir,
    input wire logic write_or_data_strobe,
    input wire logic address_phase,
    input wire logic [7:0] addr_data_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic [7:0] host_addr,
    output logic host_read,
    output logic host_write,
    input wire logic [15:0] host_wdata,
    input wire logic cmd_valid,
    input wire dma_cmd_s cmd,
    input wire dma_cfg_s dma_cfg,
    output logic dma_busy,
    output logic dma_done,
    input wire logic dma_ack,
    output logic dma_req,
    output logic dma_read_strobe,
    output logic dma_write_strobe,
    input wire logic usb_wr_valid,
    input wire logic [15:0] usb_wr_data,
    input wire logic [EP_W-1:0] usb_wr_ep,
    input wire logic mcu_ep_read_done,
    input wire logic clear_buffer_bit,
    input wire logic [EP_W-1:0] clear_ep,
    output logic [LEN_W-1:0] ep_fill,
    input wire logic [EP_W-1:0] status_ep,
    input wire logic pullup_connect,
    output logic pullup_pin,
    input wire logic bus_reset,
    input wire logic host_chirp_seen,
    input wire logic bus_activity,
    input wire logic se0_level,
    output logic hs_mode,
    output logic chirp_drive,
    output logic suspended
);
    // ==========================================================
    // Strap capture
    strap_s strap_reg;
    logic strap_taken_reg;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strap_reg <= STRAP_RESET;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_reg <= '{bus_config_select, strobe_style_select, address_latch_style}; // RULE9
            strap_taken_reg <= 1'b1; // RULE24
        end
    end

    // ==========================================================
    // Microcontroller access decode
    logic [7:0] addr_latch_reg;
    logic rd_prev_reg;
    logic wr_prev_reg;
    wire sel = !chip_select_n && strap_taken_reg;
    wire rd_level = strap_reg.strobe_style_select ? !read_or_dir
                  : (read_or_dir && !write_or_data_strobe); // RULE11
    wire wr_level = strap_reg.strobe_style_select ? !write_or_data_strobe
                  : (!read_or_dir && !write_or_data_strobe); // RULE11
    wire data_phase = strap_reg.bus_config_select || !strap_reg.address_latch_style
                    || !address_phase; // RULE12
    wire addr_capture = !strap_reg.bus_config_select && sel
                      && (strap_reg.address_latch_style ? (address_phase && wr_level)
                                                        : address_phase); // RULE12
    wire [7:0] cur_addr = strap_reg.bus_config_select ? addr_data_in : addr_latch_reg; // RULE10
    wire rd_start = sel && data_phase && rd_level && !rd_prev_reg;
    wire wr_start = sel && data_phase && wr_level && !wr_prev_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            addr_latch_reg <= 8'h00;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            host_addr <= 8'h00;
            host_read <= 1'b0;
            host_write <= 1'b0;
        end else begin
            if (addr_capture) addr_latch_reg <= addr_data_in;
            rd_prev_reg <= sel && rd_level;
            wr_prev_reg <= sel && wr_level;
            host_addr <= cur_addr;
            host_read <= rd_start;
            host_write <= wr_start;
        end
    end

    // ==========================================================
    // Endpoint RAM and per-endpoint fill counts
    logic [15:0] ram_reg [RAM_WORDS];
    logic [LEN_W-1:0] fill_reg [1 << EP_W];
    logic [RAM_AW-1:0] rd_idx_reg;

    function automatic logic [RAM_AW-1:0] ep_base(input logic [EP_W-1:0] ep);
        ep_base = {ep, {(RAM_AW - EP_W){1'b0}}};
    endfunction : ep_base

    function automatic logic [RAM_AW-1:0] ep_addr(input logic [EP_W-1:0] ep,
                                                  input logic [LEN_W-1:0] fill);
        ep_addr = ep_base(ep) | RAM_AW'(fill[8:1]);
    endfunction : ep_addr

    // ==========================================================
    // DMA handler
    dma_state_e dma_state_reg;
    dma_cmd_s cmd_reg;
    logic [LEN_W-1:0] left_reg;
    logic bus_armed_reg;
    logic [15:0] rd_word_reg;
    logic rd_word_valid_reg;
    logic [15:0] buf_out_data;
    logic buf_out_valid;
    logic buf_in_ready;
    logic strobe_phase_reg;

    wire cmd_legal = cmd_valid && (cmd.opcode != CMD_NONE)
                   && (cmd.length[1:0] & LEN_ALIGN_MASK) == 2'h0; // RULE1
    wire cmd_take = cmd_legal && (dma_state_reg == DMA_IDLE);
    wire [LEN_W-1:0] step = (cmd_reg.opcode == CMD_GENERIC_DMA_SLAVE && !dma_cfg.width16) ? 13'h0001
                          : 13'h0002; // RULE4
    wire send_ack = dma_cfg.use_handshake ? dma_ack : 1'b1; // RULE3
    wire word_out = (dma_state_reg == DMA_SEND) && buf_out_valid && send_ack
                  && strobe_phase_reg;
    wire word_in = (dma_state_reg == DMA_RECV) && send_ack && strobe_phase_reg
                 && (left_reg != 13'h0000);
    wire [RAM_AW-1:0] src_end = ep_addr(cmd_reg.endpoint, fill_reg[cmd_reg.endpoint]);
    wire ram_fetch = (dma_state_reg == DMA_SEND) && buf_in_ready && !rd_word_valid_reg
                   && (rd_idx_reg != src_end) && (left_reg != 13'h0000); // RULE2
    wire ram_push = rd_word_valid_reg && buf_in_ready;
    wire [LEN_W-1:0] left_after = (left_reg > step) ? left_reg - step : 13'h0000;

    word_buffer #(.WIDTH(16)) u_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_data(rd_word_reg),
        .in_valid(rd_word_valid_reg),
        .in_ready(buf_in_ready),
        .out_data(buf_out_data),
        .out_valid(buf_out_valid),
        .out_ready(word_out)
    );

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dma_state_reg <= DMA_IDLE;
            cmd_reg <= '0;
            left_reg <= '0;
            bus_armed_reg <= 1'b0;
            rd_word_reg <= 16'h0000;
            rd_word_valid_reg <= 1'b0;
            rd_idx_reg <= '0;
            strobe_phase_reg <= 1'b0;
            dma_done <= 1'b0;
        end else begin
            dma_done <= 1'b0;
            strobe_phase_reg <= (dma_state_reg == DMA_SEND || dma_state_reg == DMA_RECV)
                              ? ~strobe_phase_reg : 1'b0; // RULE3
            if (ram_fetch) begin
                rd_word_reg <= ram_reg[rd_idx_reg]; // RULE2
                rd_word_valid_reg <= 1'b1;
                rd_idx_reg <= rd_idx_reg + 12'h001;
            end else if (ram_push) begin
                rd_word_valid_reg <= 1'b0;
            end
            case (dma_state_reg)
                DMA_IDLE: begin
                    if (cmd_take) begin
                        cmd_reg <= cmd;
                        left_reg <= cmd.length;
                        bus_armed_reg <= 1'b1; // RULE23
                        rd_idx_reg <= ep_base(cmd.endpoint);
                        dma_state_reg <= cmd.to_device ? DMA_SEND : DMA_RECV; // RULE2
                    end
                end
                DMA_SEND: begin
                    if (word_out) left_reg <= left_after;
                    if (left_reg == 13'h0000 && !buf_out_valid) dma_state_reg <= DMA_DONE;
                end
                DMA_RECV: begin
                    if (word_in) left_reg <= left_after;
                    if (left_reg == 13'h0000) dma_state_reg <= DMA_DONE;
                end
                DMA_DONE: begin
                    dma_done <= 1'b1;
                    dma_state_reg <= DMA_IDLE;
                end
                default: dma_state_reg <= DMA_IDLE;
            endcase
        end
    end

    // ==========================================================
    // RAM write port and release
    wire usb_write = usb_wr_valid && !word_in; // RULE19
    wire [EP_W-1:0] fill_ep = word_in ? cmd_reg.endpoint : usb_wr_ep;
    wire [RAM_AW-1:0] wr_addr = ep_addr(fill_ep, fill_reg[fill_ep]);
    wire drain_done = (dma_state_reg == DMA_DONE) && cmd_reg.to_device;
    wire release_any = mcu_ep_read_done || drain_done || clear_buffer_bit;
    wire [EP_W-1:0] release_ep = clear_buffer_bit ? clear_ep
                               : (drain_done ? cmd_reg.endpoint : status_ep);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < (1 << EP_W); i++) fill_reg[i] <= '0;
        end else begin
            if (word_in || usb_write) fill_reg[fill_ep] <= fill_reg[fill_ep] + 13'h0002;
            if (release_any) fill_reg[release_ep] <= '0; // RULE6 RULE7
        end
    end

    always_ff @(posedge clk_sys) begin
        if (word_in) ram_reg[wr_addr] <= data_in; // RULE2
        else if (usb_write) ram_reg[wr_addr] <= usb_wr_data; // RULE14
    end

    // ==========================================================
    // DMA pins and host data outputs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= 16'h0000;
            data_oe <= 1'b0;
            dma_req <= 1'b0;
            dma_read_strobe <= 1'b0;
            dma_write_strobe <= 1'b0;
            dma_busy <= 1'b0;
            ep_fill <= '0;
        end else begin
            data_out <= buf_out_data;
            data_oe <= bus_armed_reg && dma_state_reg == DMA_SEND && buf_out_valid; // RULE23
            dma_req <= dma_cfg.use_handshake && (dma_state_reg == DMA_SEND
                     || dma_state_reg == DMA_RECV); // RULE3
            dma_read_strobe <= !dma_cfg.use_handshake && word_out; // RULE3
            dma_write_strobe <= !dma_cfg.use_handshake && word_in; // RULE3
            dma_busy <= dma_state_reg != DMA_IDLE;
            ep_fill <= fill_reg[status_ep];
        end
    end

    // ==========================================================
    // Speed detection
    speed_state_e spd_reg;
    speed_state_e spd_next;
    logic [TIMER_W-1:0] timer_reg;
    wire hs_idle_hit = timer_reg >= TIMER_W'(HS_IDLE_CYC);
    wire se0_ok = timer_reg >= TIMER_W'(SE0_MIN_CYC);
    wire se0_late = timer_reg >= TIMER_W'(SE0_MAX_CYC);
    wire chirp_out = timer_reg >= TIMER_W'(CHIRP_CYC);

    always_comb begin
        spd_next = spd_reg;
        case (spd_reg)
            SPD_FS: if (bus_reset) spd_next = SPD_CHIRP; // RULE15
            SPD_CHIRP: begin
                if (host_chirp_seen) spd_next = SPD_HS; // RULE16
                else if (chirp_out) spd_next = SPD_FS;
            end
            SPD_HS: if (!bus_activity && hs_idle_hit) spd_next = SPD_SE0_CHECK; // RULE17
            SPD_SE0_CHECK: begin
                if (se0_level && se0_ok) spd_next = SPD_CHIRP; // RULE18
                else if (!se0_level || se0_late) spd_next = SPD_SUSPEND; // RULE18
            end
            SPD_SUSPEND: begin
                if (bus_reset) spd_next = SPD_CHIRP;
                else if (bus_activity) spd_next = SPD_FS;
            end
            default: spd_next = SPD_FS;
        endcase
    end

    wire timer_restart = (spd_next != spd_reg) || (bus_activity && spd_reg == SPD_HS)
                       || (spd_reg == SPD_SE0_CHECK && !se0_level); // RULE25

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            spd_reg <= SPD_FS;
            timer_reg <= '0;
            hs_mode <= 1'b0;
            chirp_drive <= 1'b0;
            suspended <= 1'b0;
            pullup_pin <= 1'b0;
        end else begin
            spd_reg <= spd_next;
            timer_reg <= timer_restart ? '0 : timer_reg + TIMER_W'(1); // RULE25
            hs_mode <= spd_next == SPD_HS;
            chirp_drive <= spd_next == SPD_CHIRP; // RULE16
            suspended <= spd_next == SPD_SUSPEND;
            pullup_pin <= pullup_connect; // RULE20 RULE21
        end
    end

    // ==========================================================
    // Checks
    a_pullup_follows: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE20
        pullup_connect |=> pullup_pin) else $error("pull-up not connected");
    a_bus_idle_first: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE23
        !bus_armed_reg |-> !data_oe) else $error("DMA bus driven early");
    a_strap_stable: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE24
        $past(strap_taken_reg) |-> $stable(strap_reg)) else $error("strap changed");
    a_fs_until_reset: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE15
        (spd_reg == SPD_FS && !bus_reset) |=> spd_reg == SPD_FS) else $error("left FS");
    a_hs_after_chirp: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE16
        (spd_reg == SPD_CHIRP && host_chirp_seen) |=> hs_mode) else $error("no HS");
    a_hs_idle_exit: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE17
        (spd_reg == SPD_HS && !bus_activity && hs_idle_hit) |=> spd_reg == SPD_SE0_CHECK)
        else $error("HS idle not left");
    a_se0_rechirp: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE18
        (spd_reg == SPD_SE0_CHECK && se0_level && se0_ok) |=> chirp_drive)
        else $error("no rechirp");
    a_clear_empties: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
        clear_buffer_bit |=> fill_reg[$past(clear_ep)] == '0) else $error("clear failed");
    a_cmd_starts: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
        cmd_take |=> ##1 dma_busy) else $error("DMA not started");
    c_hs_entry: cover property (@(posedge clk_sys) disable iff (!reset_n) spd_reg == SPD_HS);
    c_suspend: cover property (@(posedge clk_sys) disable iff (!reset_n) suspended);
    c_dma_done: cover property (@(posedge clk_sys) disable iff (!reset_n) dma_done);
endmodule : usb_peripheral_front_end

// *** front_end_pkg.sv ***
// Purpose: Shared constants, states and carriers of the USB peripheral front end
// Assumes: 20 MHz system clock
// Notes: Times are given in their own unit; cycle counts derive from them
package front_end_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned HS_IDLE_US = 3000;
    localparam int unsigned SE0_MIN_US = 100;
    localparam int unsigned SE0_MAX_US = 875;
    localparam int unsigned CHIRP_US = 1000;
    localparam int unsigned HS_IDLE_CYC = HS_IDLE_US * (CLK_HZ / 1000000);
    localparam int unsigned SE0_MIN_CYC = SE0_MIN_US * (CLK_HZ / 1000000);
    localparam int unsigned SE0_MAX_CYC = SE0_MAX_US * (CLK_HZ / 1000000);
    localparam int unsigned CHIRP_CYC = CHIRP_US * (CLK_HZ / 1000000);
    localparam int TIMER_W = 17;

    // ==========================================================
    // Endpoint RAM
    localparam int RAM_BYTES = 8192;
    localparam int RAM_WORDS = RAM_BYTES / 2;
    localparam int RAM_AW = 12;
    localparam int EP_W = 4;
    localparam int LEN_W = 13;
    localparam logic [1:0] LEN_ALIGN_MASK = 2'h3;

    // ==========================================================
    // DMA commands, DMA states and speed states
    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_GENERIC_DMA_SLAVE = 2'b01,
        CMD_PIO = 2'b10,
        CMD_MDMA = 2'b11
    } dma_cmd_e;

    typedef enum logic [2:0] {
        DMA_IDLE = 3'b000,
        DMA_READ = 3'b001,
        DMA_SEND = 3'b010,
        DMA_RECV = 3'b011,
        DMA_DONE = 3'b100
    } dma_state_e;

    typedef enum logic [2:0] {
        SPD_FS = 3'b000,
        SPD_CHIRP = 3'b001,
        SPD_HS = 3'b010,
        SPD_SE0_CHECK = 3'b011,
        SPD_SUSPEND = 3'b100
    } speed_state_e;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic bus_config_select;
        logic strobe_style_select;
        logic address_latch_style;
    } strap_s;

    typedef struct packed {
        dma_cmd_e opcode;
        logic to_device;
        logic [EP_W-1:0] endpoint;
        logic [LEN_W-1:0] length;
    } dma_cmd_s;

    typedef struct packed {
        logic use_handshake;
        logic width16;
    } dma_cfg_s;

    localparam strap_s STRAP_RESET = '{1'b1, 1'b1, 1'b1};

endpackage : front_end_pkg

// *** word_buffer.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock, asynchronous active low reset
// Notes: Full and empty are exact; a stalled drain side fills it
`timescale 1ns/10ps
module word_buffer #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] slot_reg [2];
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic [1:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = slot_reg[rd_ptr_reg];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) slot_reg[wr_ptr_reg] <= in_data;
    end

    a_buf_no_overfill: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count_reg <= 2'h2) else $error("buffer count beyond two");
endmodule : word_buffer

// *** dma_far_end.sv ***
// Purpose: Far-side DMA device model facing the front end
// Assumes: Acknowledge follows request after a set delay
// Notes: Data lines change every cycle, never hold a stale word
`timescale 1ns/10ps
module dma_far_end #(
    parameter int ACK_DELAY = 2
) (
    input wire logic clk_sys,
    input wire logic dma_req,
    output logic dma_ack,
    output logic [15:0] data_in
);
    // ==========================================================
    // Handshake answer and data pattern
    int wait_cnt = 0;
    logic [15:0] pat_reg = 16'hC3A0;
    always @(posedge clk_sys) begin
        pat_reg <= pat_reg + 16'h0101;
        wait_cnt <= dma_req ? wait_cnt + 1 : 0;
    end
    assign dma_ack = dma_req && (wait_cnt >= ACK_DELAY);
    assign data_in = pat_reg;
endmodule : dma_far_end

// *** usb_peripheral_front_end_tb.sv ***
// Purpose: Self-checking bench of the USB peripheral front end
// Assumes: Straps high; far-side model answers DMA requests
// Notes: Speed idle test runs the full idle count
`timescale 1ns/10ps
module usb_peripheral_front_end_tb;
    import front_end_pkg::*;
    // ==========================================================
    // Signals
    logic clk_sys = 0, reset_n = 0, chip_select_n = 1, read_or_dir = 1;
    logic write_or_data_strobe = 1, address_phase = 0, cmd_valid = 0, dma_ack;
    logic bus_config_select = 1, strobe_style_select = 1, address_latch_style = 1;
    logic usb_wr_valid = 0, mcu_ep_read_done = 0, clear_buffer_bit = 0, pullup_connect = 0;
    logic bus_reset = 0, host_chirp_seen = 0, bus_activity = 0, se0_level = 0;
    logic data_oe, host_read, host_write, dma_busy, dma_done, dma_req, dma_read_strobe;
    logic dma_write_strobe, pullup_pin, hs_mode, chirp_drive, suspended;
    logic [7:0] addr_data_in = 8'h00, host_addr;
    logic [15:0] data_in, data_out, usb_wr_data = 16'h0000;
    logic [EP_W-1:0] usb_wr_ep = 4'h1, clear_ep = 4'h0, status_ep = 4'h1;
    logic [LEN_W-1:0] ep_fill;
    dma_cmd_s cmd = '0;
    dma_cfg_s dma_cfg = '{1'b1, 1'b1};
    logic [6:0] mon;
    logic [2:0] rows [4] = '{3'b101, 3'b111, 3'b010, 3'b000};
    int err_total = 0, num_checks = 0, cyc = 0, n;
    assign mon = {~hs_mode, hs_mode, chirp_drive, dma_done, dma_busy, host_write, host_read};
    always #25 clk_sys = ~clk_sys;
    // ==========================================================
    // Instances
    usb_peripheral_front_end i_usb_peripheral_front_end (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus_config_select(bus_config_select), .strobe_style_select(strobe_style_select),
        .address_latch_style(address_latch_style), .chip_select_n(chip_select_n),
        .read_or_dir(read_or_dir), .write_or_data_strobe(write_or_data_strobe),
        .address_phase(address_phase), .addr_data_in(addr_data_in), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .host_addr(host_addr), .host_read(host_read),
        .host_write(host_write), .host_wdata(16'h0000), .cmd_valid(cmd_valid), .cmd(cmd),
        .dma_cfg(dma_cfg), .dma_busy(dma_busy), .dma_done(dma_done), .dma_ack(dma_ack),
        .dma_req(dma_req), .dma_read_strobe(dma_read_strobe), .dma_write_strobe(dma_write_strobe),
        .usb_wr_valid(usb_wr_valid), .usb_wr_data(usb_wr_data), .usb_wr_ep(usb_wr_ep),
        .mcu_ep_read_done(mcu_ep_read_done), .clear_buffer_bit(clear_buffer_bit),
        .clear_ep(clear_ep), .ep_fill(ep_fill), .status_ep(status_ep),
        .pullup_connect(pullup_connect), .pullup_pin(pullup_pin), .bus_reset(bus_reset),
        .host_chirp_seen(host_chirp_seen), .bus_activity(bus_activity), .se0_level(se0_level),
        .hs_mode(hs_mode), .chirp_drive(chirp_drive), .suspended(suspended));
    dma_far_end i_dma_far_end (.clk_sys(clk_sys), .dma_req(dma_req), .dma_ack(dma_ack),
        .data_in(data_in));
    // ==========================================================
    // Tasks
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk_val
    task automatic ticks(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : ticks
    task automatic wait_sig(input int idx, input int lim);
        n = 0;
        while (mon[idx] !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk_bit(mon[idx], 1'b1);
        ticks(1);
    endtask : wait_sig
    task automatic do_reset;
        reset_n = 0;
        ticks(5);
        chk_val({9'h000, mon[6:0] & 7'h3F}, 16'h0000);
        chk_val({13'h0000, data_oe, pullup_pin, dma_req}, 16'h0000);
        reset_n = 1;
        ticks(2);
    endtask : do_reset
    task automatic put_words(input logic [EP_W-1:0] ep, input int cnt);
        usb_wr_ep = ep;
        usb_wr_valid = 1;
        for (int i = 0; i < cnt; i++) begin
            usb_wr_data = 16'hA500 + 16'(i);
            ticks(1);
        end
        usb_wr_valid = 0;
        ticks(1);
    endtask : put_words
    task automatic send_cmd(input dma_cmd_e op, input logic td, input int len);
        cmd = '{op, td, status_ep, len[LEN_W-1:0]};
        cmd_valid = 1;
        ticks(1);
        cmd_valid = 0;
    endtask : send_cmd
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            {pullup_connect, bus_reset} = rows[i][2:1];
            ticks(2);
            chk_bit(pullup_pin, rows[i][0]);
        end
        bus_reset = 0;
        do_reset();
        addr_data_in = 8'h5A;
        chip_select_n = 0;
        read_or_dir = 0;
        wait_sig(0, 4);
        chk_val({8'h00, host_addr}, 16'h005A);
        read_or_dir = 1;
        write_or_data_strobe = 0;
        wait_sig(1, 4);
        write_or_data_strobe = 1;
        chip_select_n = 1;
        put_words(4'h1, 4);
        chk_val({3'h0, ep_fill}, 16'h0008);
        send_cmd(CMD_GENERIC_DMA_SLAVE, 1'b1, 6);
        ticks(4);
        chk_bit(dma_busy, 1'b0);
        send_cmd(CMD_GENERIC_DMA_SLAVE, 1'b1, 8);
        wait_sig(2, 4);
        ticks(2);
        chk_bit(data_oe, 1'b1);
        chk_bit(dma_req, 1'b1);
        chk_val(data_out, 16'hA500);
        ticks(2);
        chk_val(data_out, 16'hA501);
        wait_sig(3, 200);
        ticks(2);
        chk_val({3'h0, ep_fill}, 16'h0000);
        dma_cfg = '{1'b0, 1'b1};
        status_ep = 4'h3;
        for (int k = 1; k < 4; k++) begin
            send_cmd(dma_cmd_e'(k[1:0]), 1'b0, 4);
            wait_sig(3, 200);
            ticks(2);
        end
        chk_val({3'h0, ep_fill}, 16'h000C);
        mcu_ep_read_done = 1;
        ticks(1);
        mcu_ep_read_done = 0;
        ticks(2);
        chk_val({3'h0, ep_fill}, 16'h0000);
        status_ep = 4'h2;
        clear_ep = 4'h2;
        put_words(4'h2, 2);
        clear_buffer_bit = 1;
        ticks(2);
        clear_buffer_bit = 0;
        ticks(2);
        chk_val({3'h0, ep_fill}, 16'h0000);
        bus_reset = 1;
        wait_sig(4, 20);
        chk_bit(hs_mode, 1'b0);
        host_chirp_seen = 1;
        ticks(2);
        bus_reset = 0;
        host_chirp_seen = 0;
        wait_sig(5, 40);
        bus_activity = 1;
        ticks(1);
        bus_activity = 0;
        ticks(int'(HS_IDLE_CYC) - 40);
        chk_bit(hs_mode, 1'b1);
        se0_level = 1;
        wait_sig(6, 80);
        wait_sig(4, int'(SE0_MIN_CYC) + 100);
        tally_and_finish();
    end
endmodule : usb_peripheral_front_end_tb
